// ==== core/tcc_defs.vh ====
// Register addresses, field positions, codes and counts of the 16-bit timer/counter.
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// I/O addresses of the byte registers.
`define TCC_ADDR_CAPTURE_LOW  6'h26
`define TCC_ADDR_CAPTURE_HIGH 6'h27
`define TCC_ADDR_COMPARE_LOW  6'h2a
`define TCC_ADDR_COMPARE_HIGH 6'h2b
`define TCC_ADDR_COUNTER_LOW  6'h2c
`define TCC_ADDR_COUNTER_HIGH 6'h2d
`define TCC_ADDR_CONTROL_B    6'h2e
`define TCC_ADDR_CONTROL_A    6'h2f

// Field positions in control register B.
`define TCC_B_NOISE_FILTER    7
`define TCC_B_EDGE_SELECT     6
`define TCC_B_CLEAR_ON_MATCH  3

// Writable bits of the control registers, and reset values of the control, word and byte registers.
`define TCC_B_WRITE_MASK      8'hcf
`define TCC_A_WRITE_MASK      8'hc3
`define TCC_CONTROL_RESET     8'h00
`define TCC_WORD_RESET        16'h0000
`define TCC_BYTE_RESET        8'h00

// Clock select codes.
`define TCC_CS_STOP           3'h0
`define TCC_CS_DIV1           3'h1
`define TCC_CS_DIV8           3'h2
`define TCC_CS_DIV64          3'h3
`define TCC_CS_DIV256         3'h4
`define TCC_CS_DIV1024        3'h5
`define TCC_CS_EXT_FALL       3'h6
`define TCC_CS_EXT_RISE       3'h7

// Prescaler width and terminal masks for each division.
`define TCC_PRESCALE_BITS     10
`define TCC_PRE_MASK8         10'h007
`define TCC_PRE_MASK64        10'h03f
`define TCC_PRE_MASK256       10'h0ff
`define TCC_PRE_MASK1024      10'h3ff

// Modulation modes and their turning points.
`define TCC_PWM_OFF           2'h0
`define TCC_PWM_8BIT          2'h1
`define TCC_PWM_9BIT          2'h2
`define TCC_PWM_10BIT         2'h3
`define TCC_TOP_8BIT          16'h00ff
`define TCC_TOP_9BIT          16'h01ff
`define TCC_TOP_10BIT         16'h03ff

// Number of agreeing samples the capture noise filter needs.
`define TCC_FILTER_SAMPLES    4

// Last value of the settling count that holds off pin edges after reset.
`define TCC_SETTLE_LAST       4'hf

`endif

// ==== core/tcc_pin_sync.v ====
// Three-stage synchroniser with agreement filter for asynchronous input pins.
`timescale 1ns/1ps

module tcc_pin_sync #(
	parameter WIDTH = 2
) (
	input  wire             clk_sys,   // System clock.
	input  wire             rst,       // Asynchronous reset, active high.
	input  wire [WIDTH-1:0] pin_in,    // Raw pin levels.
	output wire [WIDTH-1:0] level_out  // Accepted pin levels.
);

	genvar g;

	// One chain per pin; a level is accepted once stages two and three agree.
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg level_q;

			always @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					s1_q    <= 1'b0;
					s2_q    <= 1'b0;
					s3_q    <= 1'b0;
					level_q <= 1'b0;
				end else begin
					s1_q <= pin_in[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						level_q <= s3_q;
					end
				end
			end

			assign level_out[g] = level_q;
		end
	endgenerate

endmodule // tcc_pin_sync

// ==== core/tcc_timer16.v ====
// Top of the 16-bit timer/counter with compare, clear on match and capture.
`timescale 1ns/1ps
`include "tcc_defs.vh"

module tcc_timer16 #(
	parameter FILTER_SAMPLES = `TCC_FILTER_SAMPLES
) (
	input  wire       clk_sys,          // System clock, 20 MHz.
	input  wire       rst,              // Asynchronous reset, active high.
	input  wire [5:0] io_addr,          // Register address.
	input  wire [7:0] io_wdata,         // Write data.
	input  wire       io_wr,            // Write strobe, one cycle.
	input  wire       io_rd,            // Read strobe, one cycle.
	output wire [7:0] io_rdata,         // Read data, valid the cycle after io_rd.
	input  wire       capture_input_pin,  // Asynchronous capture pin.
	input  wire       external_count_pin, // Asynchronous count pin.
	input  wire       capture_flag_clr, // Clears the capture flag, one cycle.
	output wire       capture_flag,     // Sticky capture flag.
	output wire       compare_match,    // One-cycle pulse on a compare match.
	output wire       capture_event     // One-cycle pulse on a capture.
);

	// Control register fields.
	reg  [7:0]  control_a_q;
	reg  [7:0]  control_b_q;
	wire [2:0]  clock_select;
	wire        clear_on_match;
	wire        capture_edge_select;
	wire        capture_noise_filter_enable;
	wire [1:0]  pwm_mode;
	wire        pwm_active;

	// Timer state.
	reg  [15:0] counter_value_q;
	reg  [15:0] counter_value_d;
	reg  [15:0] compare_value_q;
	reg  [15:0] capture_value_q;
	reg  [7:0]  shared_latch_q;
	reg         count_down_q;
	reg         count_down_d;
	reg  [`TCC_PRESCALE_BITS-1:0] prescale_q;
	reg         tick_q;
	reg         timer_tick;
	reg  [15:0] pwm_top;

	// Pin handling.
	wire [1:0]  pin_level;
	reg         count_pin_prev_q;
	reg         capture_pin_prev_q;
	reg  [FILTER_SAMPLES-1:0] capture_hist_q;
	reg         capture_filtered_q;
	reg         capture_filtered_prev_q;
	wire        count_rise;
	wire        count_fall;
	wire        capture_trigger;
	reg  [3:0]  settle_q;
	wire        pins_settled;

	// Bus decode.
	wire        wr_counter_low;
	wire        wr_counter_high;
	wire        wr_compare_low;
	wire        wr_compare_high;
	wire        rd_counter_low;
	wire        rd_capture_low;

	// Match detection and output flops.
	wire        match_hit;
	reg  [7:0]  io_rdata_q;
	reg         capture_flag_q;
	reg         compare_match_q;
	reg         capture_event_q;

	assign clock_select                = control_b_q[2:0];
	assign clear_on_match              = control_b_q[`TCC_B_CLEAR_ON_MATCH];
	assign capture_edge_select         = control_b_q[`TCC_B_EDGE_SELECT];
	assign capture_noise_filter_enable = control_b_q[`TCC_B_NOISE_FILTER];
	assign pwm_mode                    = control_a_q[1:0];
	assign pwm_active                  = (pwm_mode != `TCC_PWM_OFF);

	// Address decode of the byte accesses.
	assign wr_counter_low  = io_wr && (io_addr == `TCC_ADDR_COUNTER_LOW);
	assign wr_counter_high = io_wr && (io_addr == `TCC_ADDR_COUNTER_HIGH);
	assign wr_compare_low  = io_wr && (io_addr == `TCC_ADDR_COMPARE_LOW);
	assign wr_compare_high = io_wr && (io_addr == `TCC_ADDR_COMPARE_HIGH);
	assign rd_counter_low  = io_rd && (io_addr == `TCC_ADDR_COUNTER_LOW);
	assign rd_capture_low  = io_rd && (io_addr == `TCC_ADDR_CAPTURE_LOW);

	// Both pins pass the same synchroniser; bit 0 is the count pin, bit 1 the capture pin.
	tcc_pin_sync #(
		.WIDTH (2)
	) u_pin_sync (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.pin_in    ({capture_input_pin, external_count_pin}),
		.level_out (pin_level)
	);

	// The synchroniser, the edge memories and the filter history all start at zero,
	// so a pin that idles high would look like a rising edge a few cycles after reset.
	// Edges are ignored until the settling count is full, which covers the default filter depth.
	assign pins_settled = (settle_q == `TCC_SETTLE_LAST);

	// Settling count: runs once after reset and then holds.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			settle_q <= 4'h0;
		end else if (!pins_settled) begin
			settle_q <= settle_q + 4'h1;
		end
	end

	// Edges of the accepted count pin level; the pin direction is never consulted.
	assign count_rise = pins_settled && pin_level[0] && !count_pin_prev_q;
	assign count_fall = pins_settled && !pin_level[0] && count_pin_prev_q;

	// Free-running prescaler shared by all divided rates.
	// It is not cleared on a rate change, so the first divided period may be short.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prescale_q <= {`TCC_PRESCALE_BITS{1'b0}};
		end else begin
			prescale_q <= prescale_q + 1'b1;
		end
	end

	// Timer clock enable picked by the clock select field.
	always @* begin
		case (clock_select)
			`TCC_CS_STOP:     timer_tick = 1'b0;
			`TCC_CS_DIV1:     timer_tick = 1'b1;
			`TCC_CS_DIV8:     timer_tick = ((prescale_q & `TCC_PRE_MASK8) == `TCC_PRE_MASK8);
			`TCC_CS_DIV64:    timer_tick = ((prescale_q & `TCC_PRE_MASK64) == `TCC_PRE_MASK64);
			`TCC_CS_DIV256:   timer_tick = ((prescale_q & `TCC_PRE_MASK256) == `TCC_PRE_MASK256);
			`TCC_CS_DIV1024:  timer_tick = (prescale_q == `TCC_PRE_MASK1024);
			`TCC_CS_EXT_FALL: timer_tick = count_fall;
			`TCC_CS_EXT_RISE: timer_tick = count_rise;
			default:          timer_tick = 1'b0;
		endcase
	end

	// Turning point of the up/down sweep for each modulation width.
	always @* begin
		case (pwm_mode)
			`TCC_PWM_8BIT:  pwm_top = `TCC_TOP_8BIT;
			`TCC_PWM_9BIT:  pwm_top = `TCC_TOP_9BIT;
			`TCC_PWM_10BIT: pwm_top = `TCC_TOP_10BIT;
			default:        pwm_top = `TCC_TOP_10BIT;
		endcase
	end

	// A match is judged on the cycle after the counter took a new value, so it is
	// seen one system clock late and once per count value, not once per clock.
	// Outside modulation all sixteen bits must agree; while modulating only the
	// bits below the turning point take part.
	assign match_hit = tick_q && (pwm_active ?
		((counter_value_q & pwm_top) == (compare_value_q & pwm_top)) :
		(counter_value_q == compare_value_q));

	// Next counter value: a write wins, then clear on match, then a timer tick.
	// A written value stands until the next timer tick moves it on.
	always @* begin
		counter_value_d = counter_value_q;
		count_down_d    = count_down_q;
		if (wr_counter_low) begin
			counter_value_d = {shared_latch_q, io_wdata};
		end else if (match_hit && clear_on_match && !pwm_active) begin
			counter_value_d = `TCC_WORD_RESET;
		end else if (timer_tick) begin
			if (!pwm_active) begin
				counter_value_d = counter_value_q + 16'h0001;
				count_down_d    = 1'b0;
			end else if (!count_down_q) begin
				if (counter_value_q >= pwm_top) begin
					counter_value_d = counter_value_q - 16'h0001;
					count_down_d    = 1'b1;
				end else begin
					counter_value_d = counter_value_q + 16'h0001;
				end
			end else begin
				if (counter_value_q == `TCC_WORD_RESET) begin
					counter_value_d = counter_value_q + 16'h0001;
					count_down_d    = 1'b0;
				end else begin
					counter_value_d = counter_value_q - 16'h0001;
				end
			end
		end
	end

	// Counter, direction and the delayed tick used for match detection.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			counter_value_q  <= `TCC_WORD_RESET;
			count_down_q     <= 1'b0;
			tick_q           <= 1'b0;
			count_pin_prev_q <= 1'b0;
		end else begin
			counter_value_q  <= counter_value_d;
			count_down_q     <= count_down_d;
			tick_q           <= timer_tick && !wr_counter_low;
			count_pin_prev_q <= pin_level[0];
		end
	end

	// Capture noise filter: a new level is taken only when the last samples all agree.
	// With the filter off the level still passes one register; turning it on adds FILTER_SAMPLES cycles of delay.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			capture_hist_q          <= {FILTER_SAMPLES{1'b0}};
			capture_filtered_q      <= 1'b0;
			capture_filtered_prev_q <= 1'b0;
			capture_pin_prev_q      <= 1'b0;
		end else begin
			capture_pin_prev_q      <= pin_level[1];
			capture_hist_q          <= {capture_hist_q[FILTER_SAMPLES-2:0], pin_level[1]};
			capture_filtered_prev_q <= capture_filtered_q;
			if (!capture_noise_filter_enable) begin
				capture_filtered_q <= pin_level[1];
			end else if (&capture_hist_q) begin
				capture_filtered_q <= 1'b1;
			end else if (~|capture_hist_q) begin
				capture_filtered_q <= 1'b0;
			end
		end
	end

	// Capture trigger on the edge chosen by the edge select bit.
	assign capture_trigger = pins_settled && (capture_edge_select ?
		(capture_filtered_q && !capture_filtered_prev_q) :
		(!capture_filtered_q && capture_filtered_prev_q));

	// Capture register, flag and event pulse; a new capture beats a clear.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			capture_value_q <= `TCC_WORD_RESET;
			capture_flag_q  <= 1'b0;
			capture_event_q <= 1'b0;
		end else begin
			capture_event_q <= capture_trigger;
			if (capture_trigger) begin
				capture_value_q <= counter_value_q;
				capture_flag_q  <= 1'b1;
			end else if (capture_flag_clr) begin
				capture_flag_q  <= 1'b0;
			end
		end
	end

	// Compare register: the high byte waits in the latch until the low byte arrives.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			compare_value_q <= `TCC_WORD_RESET;
		end else if (wr_compare_low) begin
			compare_value_q <= {shared_latch_q, io_wdata};
		end
	end

	// The one byte latch: high writes and counter or capture low reads fill it.
	// A lone low write takes whatever the latch last held as its high byte.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			shared_latch_q <= `TCC_BYTE_RESET;
		end else if (wr_counter_high || wr_compare_high) begin
			shared_latch_q <= io_wdata;
		end else if (rd_counter_low) begin
			shared_latch_q <= counter_value_q[15:8];
		end else if (rd_capture_low) begin
			shared_latch_q <= capture_value_q[15:8];
		end
	end

	// Control registers; reserved bits are never stored.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			control_a_q <= `TCC_CONTROL_RESET;
			control_b_q <= `TCC_CONTROL_RESET;
		end else begin
			if (io_wr && (io_addr == `TCC_ADDR_CONTROL_A)) begin
				control_a_q <= io_wdata & `TCC_A_WRITE_MASK;
			end
			if (io_wr && (io_addr == `TCC_ADDR_CONTROL_B)) begin
				control_b_q <= io_wdata & `TCC_B_WRITE_MASK;
			end
		end
	end

	// Read data registered one cycle after the strobe; unmapped addresses read zero.
	// Compare reads bypass the latch; counter and capture high reads return it.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			io_rdata_q <= `TCC_BYTE_RESET;
		end else if (io_rd) begin
			case (io_addr)
				`TCC_ADDR_CAPTURE_LOW:  io_rdata_q <= capture_value_q[7:0];
				`TCC_ADDR_CAPTURE_HIGH: io_rdata_q <= shared_latch_q;
				`TCC_ADDR_COMPARE_LOW:  io_rdata_q <= compare_value_q[7:0];
				`TCC_ADDR_COMPARE_HIGH: io_rdata_q <= compare_value_q[15:8];
				`TCC_ADDR_COUNTER_LOW:  io_rdata_q <= counter_value_q[7:0];
				`TCC_ADDR_COUNTER_HIGH: io_rdata_q <= shared_latch_q;
				`TCC_ADDR_CONTROL_B:    io_rdata_q <= control_b_q & `TCC_B_WRITE_MASK;
				`TCC_ADDR_CONTROL_A:    io_rdata_q <= control_a_q & `TCC_A_WRITE_MASK;
				default:                io_rdata_q <= `TCC_BYTE_RESET;
			endcase
		end
	end

	// Compare match pulse, raised in the same cycle the clear takes effect.
	// It leans on the delayed tick, so a value written equal to the compare gives no pulse.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			compare_match_q <= 1'b0;
		end else begin
			compare_match_q <= match_hit;
		end
	end

	// Outputs come straight from flip-flops.
	assign io_rdata      = io_rdata_q;
	assign capture_flag  = capture_flag_q;
	assign compare_match = compare_match_q;
	assign capture_event = capture_event_q;

endmodule // tcc_timer16

// ==== test/tcc_timer16_properties.sv ====
// Concurrent checks on the ports of the 16-bit timer/counter.
`timescale 1ns/1ps
`include "tcc_defs.vh"

module tcc_timer16_properties #(
	parameter FILTER_SAMPLES = 4
) (
	input wire       clk_sys,            // System clock.
	input wire       rst,                // Asynchronous reset.
	input wire [5:0] io_addr,            // Register address.
	input wire [7:0] io_wdata,           // Write data.
	input wire       io_wr,              // Write strobe.
	input wire       io_rd,              // Read strobe.
	input wire [7:0] io_rdata,           // Read data.
	input wire       capture_input_pin,  // Capture pin.
	input wire       external_count_pin, // Count pin.
	input wire       capture_flag_clr,   // Flag clear.
	input wire       capture_flag,       // Capture flag.
	input wire       compare_match,      // Match pulse.
	input wire       capture_event       // Capture pulse.
);
	// All checks run on the system clock and rest during reset.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// Read data, pulses and the sticky flag.
	read_hold_a: assert property (!io_rd |=> $stable(io_rdata)) else $error("read data moved");
	reserved_zero_a: assert property (io_rd && io_addr == `TCC_ADDR_CONTROL_B |=> io_rdata[5:4] == 2'h0)
		else $error("reserved bits not zero");
	match_single_a: assert property (compare_match |=> !compare_match) else $error("match too long");
	event_single_a: assert property (capture_event |=> !capture_event) else $error("capture too long");
	flag_set_a: assert property (capture_event |-> capture_flag) else $error("flag not set");
	flag_rise_a: assert property ($rose(capture_flag) |-> capture_event) else $error("flag without capture");
	flag_sticky_a: assert property (capture_flag && !capture_flag_clr |=> capture_flag)
		else $error("flag dropped");
	flag_clear_a: assert property (capture_flag_clr |=> capture_event || !capture_flag)
		else $error("flag not cleared");

	// Main scenarios seen.
	match_seen_c: cover property (compare_match);
	capture_seen_c: cover property (capture_event);
	clear_seen_c: cover property (capture_flag && capture_flag_clr);
endmodule // tcc_timer16_properties

bind tcc_timer16 tcc_timer16_properties #(.FILTER_SAMPLES(FILTER_SAMPLES)) u_props (
	.clk_sys(clk_sys), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
	.io_rd(io_rd), .io_rdata(io_rdata), .capture_input_pin(capture_input_pin),
	.external_count_pin(external_count_pin), .capture_flag_clr(capture_flag_clr),
	.capture_flag(capture_flag), .compare_match(compare_match), .capture_event(capture_event));

// ==== test/tcc_pin_model.sv ====
// Model of the outside pins that feed the capture and count inputs.
`timescale 1ns/1ps

module tcc_pin_model (
	input  wire clk_sys,            // System clock.
	output reg  capture_input_pin,  // Capture pin level.
	output reg  external_count_pin  // Count pin level.
);
	// Both pins idle high until a task moves them.
	initial begin
		capture_input_pin = 1'b1;
		external_count_pin = 1'b1;
	end

	// Moves the capture pin just after a clock edge.
	task cap_set(input v);
		begin
			@(posedge clk_sys);
			#1 capture_input_pin = v;
		end
	endtask

	// Gives k low pulses, each level held four clocks, as software toggling would.
	task cnt_pulses(input int k);
		int i;
		begin
			for (i = 0; i < k; i++) begin
				repeat (4) @(posedge clk_sys);
				#1 external_count_pin = 1'b0;
				repeat (4) @(posedge clk_sys);
				#1 external_count_pin = 1'b1;
			end
		end
	endtask
endmodule // tcc_pin_model

// ==== test/test_timer16_ctc_capture_core.sv ====
// Self-checking bench of the 16-bit timer/counter.
`timescale 1ns/1ps

module test_timer16_ctc_capture_core;
	logic       clk_sys;          // System clock.
	logic       rst;              // Reset.
	logic [5:0] io_addr;          // Register address.
	logic [7:0] io_wdata;         // Write data.
	logic       io_wr;            // Write strobe.
	logic       io_rd;            // Read strobe.
	logic       capture_flag_clr; // Flag clear.
	wire  [7:0] io_rdata;         // Read data.
	wire        cap_pin;          // Capture pin.
	wire        cnt_pin;          // Count pin.
	wire        capture_flag;     // Capture flag.
	wire        compare_match;    // Match pulse.
	wire        capture_event;    // Capture pulse.
	int         err_count;        // Mismatches.
	int         n_compared;       // Comparisons.
	int         i;                // Loop index.
	int         dv [1:5] = '{1, 8, 64, 256, 1024}; // Prescale divisions.

	tcc_timer16 dut (.clk_sys(clk_sys), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
		.io_rd(io_rd), .io_rdata(io_rdata), .capture_input_pin(cap_pin), .external_count_pin(cnt_pin),
		.capture_flag_clr(capture_flag_clr), .capture_flag(capture_flag), .compare_match(compare_match),
		.capture_event(capture_event));
	tcc_pin_model pm (.clk_sys(clk_sys), .capture_input_pin(cap_pin), .external_count_pin(cnt_pin));

	// Clock of 50 ns.
	always #25 clk_sys = ~clk_sys;

	task cyc(input int n);
		begin
			repeat (n) @(posedge clk_sys);
			#1;
		end
	endtask

	task chk(input [7:0] got, input [7:0] exp);
		begin
			n_compared++;
			if (got !== exp) begin
				$display("[ERR] %0t got %h exp %h", $time, got, exp);
				err_count++;
			end
		end
	endtask

	// Each access takes the edge after the strobe rises; a spare cycle follows.
	task wr(input [5:0] a, input [7:0] d);
		begin
			io_addr = a;
			io_wdata = d;
			io_wr = 1'b1;
			cyc(1);
			io_wr = 1'b0;
			cyc(1);
		end
	endtask

	task rchk(input [5:0] a, input [7:0] exp);
		begin
			io_addr = a;
			io_rd = 1'b1;
			cyc(1);
			io_rd = 1'b0;
			chk(io_rdata, exp);
			cyc(1);
		end
	endtask

	// High byte first, then the low byte one address below.
	task ld16(input [5:0] hi, input [15:0] v);
		begin
			wr(hi, v[15:8]);
			wr(hi - 6'h01, v[7:0]);
		end
	endtask

	task clr;
		begin
			capture_flag_clr = 1'b1;
			cyc(1);
			capture_flag_clr = 1'b0;
			cyc(1);
		end
	endtask

	task wmatch;
		int k;
		begin
			k = 0;
			while (compare_match !== 1'b1 && k < 400) begin
				cyc(1);
				k++;
			end
			chk({7'h00, compare_match}, 8'h01);
		end
	endtask

	task conclude;
		begin
			if (err_count == 0 && n_compared > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask

	// Cuts a hang short well beyond the expected run.
	initial begin
		#(50 * 30000);
		err_count++;
		conclude;
	end

	// Main sequence.
	initial begin
		clk_sys = 1'b0;
		rst = 1'b1;
		io_addr = 6'h00;
		io_wdata = 8'h00;
		io_wr = 1'b0;
		io_rd = 1'b0;
		capture_flag_clr = 1'b0;
		err_count = 0;
		n_compared = 0;
		cyc(20);
		rst = 1'b0;
		for (i = 0; i < 10; i++)
			rchk(6'h26 + i[5:0], 8'h00);
		rchk(6'h10, 8'h00);
		wr(6'h2e, 8'hff);
		rchk(6'h2e, 8'hcf);
		wr(6'h2e, 8'h00);
		ld16(6'h2d, 16'h1234);
		rchk(6'h2c, 8'h34);
		rchk(6'h2d, 8'h12);
		ld16(6'h2b, 16'h5678);
		rchk(6'h2b, 8'h56);
		rchk(6'h2a, 8'h78);
		wr(6'h2c, 8'h9a);
		rchk(6'h2c, 8'h9a);
		rchk(6'h2d, 8'h56);
		// Each rate runs for four of its periods from a preset value.
		for (i = 1; i < 6; i++) begin
			ld16(6'h2d, 16'h00fe);
			wr(6'h2e, i[7:0]);
			cyc(4 * dv[i] - 2);
			wr(6'h2e, 8'h00);
			rchk(6'h2c, 8'h02);
			rchk(6'h2d, 8'h01);
		end
		// Free count, clear on match, then modulation with the clear bit set.
		ld16(6'h2b, 16'h0110);
		for (i = 0; i < 3; i++) begin
			wr(6'h2f, {7'h00, i == 2});
			ld16(6'h2d, (i == 2) ? 16'h0000 : 16'h0010);
			wr(6'h2e, (i == 0) ? 8'h01 : 8'h09);
			wmatch;
			wr(6'h2e, 8'h00);
			rchk(6'h2c, (i == 1) ? 8'h01 : 8'h12);
			rchk(6'h2d, (i == 0) ? 8'h01 : 8'h00);
		end
		wr(6'h2f, 8'h00);
		for (i = 6; i < 8; i++) begin
			ld16(6'h2d, 16'h0000);
			wr(6'h2e, i[7:0]);
			pm.cnt_pulses(3);
			cyc(10);
			wr(6'h2e, 8'h00);
			rchk(6'h2c, 8'h03);
		end
		// Capture on each edge polarity of a stopped counter.
		ld16(6'h2d, 16'h1234);
		for (i = 0; i < 2; i++) begin
			wr(6'h2e, {1'b0, i[0], 6'h00});
			pm.cap_set(1'b0);
			cyc(10);
			chk({7'h00, capture_flag}, {7'h00, ~i[0]});
			clr;
			pm.cap_set(1'b1);
			cyc(10);
			chk({7'h00, capture_flag}, {7'h00, i[0]});
			clr;
		end
		rchk(6'h26, 8'h34);
		rchk(6'h27, 8'h12);
		// Filter rejects a short high pulse and accepts a held one.
		wr(6'h2e, 8'hc0);
		for (i = 0; i < 4; i++) begin
			pm.cap_set(i[0]);
			cyc((i == 1) ? 1 : 14);
			if (i == 0)
				clr;
			if (i > 1)
				chk({7'h00, capture_flag}, {7'h00, i[0]});
		end
		// Mid-run reset with pins idle high: no false edge may count or capture.
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		wr(6'h2e, 8'hc7);
		cyc(8);
		wr(6'h2e, 8'h00);
		chk({7'h00, capture_flag}, 8'h00);
		rchk(6'h2c, 8'h00);
		conclude;
	end
endmodule // test_timer16_ctc_capture_core
